// file: cie_irq_enable_capture.sv
// module: interrupt enables, flags and arbitration loss position capture behind classic Wishbone
// Notes on behaviour
// - eight-bit enable register at index 4, read and write
// - bit 7 enables bus error requests
// - bit 6 enables arbitration loss requests
// - bit 5 enables requests on error active/passive change, both ways
// - bit 4 enables wake-up requests on leaving sleep
// - bit 3 enables requests when overrun status becomes set
// - bit 2 enables requests on any error or bus status change
// - bit 1 enables requests on transmit success or buffer released
// - bit 0 enables receive request while receive buffer full
// - receive enable gates receive flag combinationally; clearing drops request one cycle later on the registered line
// - loss position register at index 11 is read only
// - upper three bits of loss position read zero
// - on loss, flag and position capture happen in the same cycle
// - captured position frozen until host reads it once
// - arbitration loss flag cleared by host read of flag register
// - no new arbitration loss flag until position register was read
// - low five bits hold binary frame bit number of loss
// - values 0..10 mean identifier bits 1..11
// - value 11 means SRTR bit, 12 means IDE bit
// - values 13..30 mean identifier bits 12..29, extended only
// - value 31 means RTR bit of extended frame
// - interrupt requested while any flag set; flag read clears all but receive
// - flag bit 6 set on arbitration loss when enabled
//
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module cie_irq_enable_capture
	import cie_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [5:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// protocol engine side
	input wire cie_events_s events_i,
	input wire logic [4:0] frame_bit_pos_i,
	// interrupt line, active low
	output logic irq_n_o
);
	// ---------------------------------------------
	// bus slave
	// ---------------------------------------------
	cie_bus_e bus_q;
	logic [7:0] enables_q;
	logic [7:1] flags_q;
	logic [4:0] loss_pos_q;
	logic capture_armed_q;
	logic [7:0] flags_view;
	logic req_take;
	logic rd_flags;
	logic rd_loss;
	logic rd_enables;
	logic wr_enables;

	function automatic logic hit(input logic [5:0] adr, input logic [5:0] target);
		hit = (adr == target);
	endfunction

	assign req_take = wb_cyc_i && wb_stb_i && (bus_q == CIE_BUS_IDLE);
	assign rd_flags = req_take && !wb_we_i && hit(wb_adr_i, CIE_ADR_FLAGS);
	assign rd_loss = req_take && !wb_we_i && hit(wb_adr_i, CIE_ADR_LOSS_POS);
	assign rd_enables = req_take && !wb_we_i && hit(wb_adr_i, CIE_ADR_ENABLES);
	assign wr_enables = req_take && wb_we_i && wb_sel_i[0] && hit(wb_adr_i, CIE_ADR_ENABLES);
	// receive flag follows buffer state, gated by its enable directly
	assign flags_view = {flags_q, events_i.rx_full && enables_q[CIE_BIT_RX_PENDING]};

	// one-wait-state answer, then a gap so ack drops after a single cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bus_q <= CIE_BUS_IDLE;
			wb_ack_o <= 1'b0;
		end else begin
			case (bus_q)
				CIE_BUS_IDLE: begin
					wb_ack_o <= req_take;
					if (req_take) begin
						bus_q <= CIE_BUS_ACK;
					end
				end
				CIE_BUS_ACK: begin
					wb_ack_o <= 1'b0;
					bus_q <= CIE_BUS_GAP;
				end
				CIE_BUS_GAP: begin
					wb_ack_o <= 1'b0;
					bus_q <= CIE_BUS_IDLE;
				end
				default: begin
					wb_ack_o <= 1'b0;
					bus_q <= CIE_BUS_IDLE;
				end
			endcase
		end
	end

	// read data; unmapped addresses read zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (req_take && !wb_we_i) begin
			if (hit(wb_adr_i, CIE_ADR_ENABLES)) begin
				wb_dat_o <= {24'h00_0000, enables_q};
			end else if (hit(wb_adr_i, CIE_ADR_LOSS_POS)) begin
				wb_dat_o <= {24'h00_0000, CIE_LOSS_RSVD, loss_pos_q};
			end else if (hit(wb_adr_i, CIE_ADR_FLAGS)) begin
				wb_dat_o <= {24'h00_0000, flags_view};
			end else begin
				wb_dat_o <= 32'h0000_0000;
			end
		end else begin
			wb_dat_o <= 32'h0000_0000;
		end
	end

	// ---------------------------------------------
	// enable register
	// ---------------------------------------------
	// only byte lane 0 carries the register; loss position has no write path
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			enables_q <= CIE_ENABLES_RST;
		end else if (wr_enables) begin
			enables_q <= wb_dat_i[7:0];
		end
	end

	// ---------------------------------------------
	// sticky flags
	// ---------------------------------------------
	logic [7:1] flag_set;
	always_comb begin
		flag_set = '0;
		flag_set[CIE_BIT_BUS_FAULT] = events_i.bus_fault && enables_q[CIE_BIT_BUS_FAULT];
		// held off while a previous capture is still unread
		flag_set[CIE_BIT_ARB_LOSS] = events_i.arb_loss && capture_armed_q &&
			enables_q[CIE_BIT_ARB_LOSS];
		flag_set[CIE_BIT_PASSIVE] = events_i.passive_change && enables_q[CIE_BIT_PASSIVE];
		flag_set[CIE_BIT_WAKE] = events_i.wake && enables_q[CIE_BIT_WAKE];
		flag_set[CIE_BIT_OVERRUN] = events_i.overrun_rise && enables_q[CIE_BIT_OVERRUN];
		flag_set[CIE_BIT_WARNING] = events_i.warning_change && enables_q[CIE_BIT_WARNING];
		flag_set[CIE_BIT_TX_DONE] = events_i.tx_released && enables_q[CIE_BIT_TX_DONE];
	end

	genvar gi;
	generate
		for (gi = 1; gi < CIE_NUM_SRC; gi++) begin : g_flag
			// a set in the read cycle wins over the read-clear
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					flags_q[gi] <= CIE_FLAGS_RST[gi];
				end else if (flag_set[gi]) begin
					flags_q[gi] <= 1'b1;
				end else if (rd_flags) begin
					flags_q[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	// ---------------------------------------------
	// arbitration loss capture
	// ---------------------------------------------
	// position codes are passed through as the engine counts them
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			loss_pos_q <= CIE_LOSS_POS_RST;
		end else if (events_i.arb_loss && capture_armed_q) begin
			loss_pos_q <= frame_bit_pos_i;
		end
	end

	// a capture beats a same-cycle read, which still returns the old position
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			capture_armed_q <= 1'b1;
		end else if (events_i.arb_loss && capture_armed_q) begin
			capture_armed_q <= 1'b0;
		end else if (rd_loss) begin
			capture_armed_q <= 1'b1;
		end
	end

	// ---------------------------------------------
	// interrupt line
	// ---------------------------------------------
	// registered for a clean pin; receive-enable clear shows one cycle later
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_n_o <= 1'b1;
		end else begin
			irq_n_o <= ~(|flags_view);
		end
	end

	// ---------------------------------------------
	// checks: bus slave
	// ---------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	ack_after_take_a: assert property (
		req_take
		|=> wb_ack_o)
		else $error("no ack after a taken request");
	ack_pulse_a: assert property (
		wb_ack_o
		|=> !wb_ack_o)
		else $error("ack longer than one cycle");
	ack_cause_a: assert property (
		wb_ack_o
		|-> $past(req_take))
		else $error("ack without a taken request");
	data_idle_a: assert property (
		!wb_ack_o
		|-> wb_dat_o == 32'h0000_0000)
		else $error("read data not zero outside ack");

	// ---------------------------------------------
	// checks: enable register
	// ---------------------------------------------
	enable_write_a: assert property (
		wr_enables
		|=> enables_q == $past(wb_dat_i[7:0]))
		else $error("enable write lost");
	enable_hold_a: assert property (
		!wr_enables
		|=> $stable(enables_q))
		else $error("enables changed without a write");
	enable_read_a: assert property (
		rd_enables
		|=> wb_dat_o[7:0] == $past(enables_q))
		else $error("enable read data wrong");

	// ---------------------------------------------
	// checks: loss position capture
	// ---------------------------------------------
	loss_ro_a: assert property (
		!(events_i.arb_loss && capture_armed_q)
		|=> $stable(loss_pos_q))
		else $error("loss position changed without a capture");
	loss_read_a: assert property (
		rd_loss
		|=> wb_dat_o[4:0] == $past(loss_pos_q))
		else $error("loss position read data wrong");
	rsvd_zero_a: assert property (
		wb_ack_o && $past(rd_loss)
		|-> wb_dat_o[7:5] == 3'h0)
		else $error("reserved loss bits nonzero");
	capture_take_a: assert property (
		events_i.arb_loss && capture_armed_q
		|=> loss_pos_q == $past(frame_bit_pos_i) && !capture_armed_q)
		else $error("loss position not captured");
	capture_frozen_a: assert property (
		!capture_armed_q && !rd_loss
		|=> $stable(loss_pos_q))
		else $error("loss position changed while frozen");
	rearm_a: assert property (
		rd_loss && !events_i.arb_loss
		|=> capture_armed_q)
		else $error("position read did not re-arm capture");
	armed_hold_a: assert property (
		!capture_armed_q && !rd_loss
		|=> !capture_armed_q)
		else $error("capture re-armed without a read");

	// ---------------------------------------------
	// checks: flags
	// ---------------------------------------------
	bus_fault_set_a: assert property (
		events_i.bus_fault && enables_q[CIE_BIT_BUS_FAULT]
		|=> flags_q[CIE_BIT_BUS_FAULT])
		else $error("bus fault flag not set");
	bus_fault_gate_a: assert property (
		!enables_q[CIE_BIT_BUS_FAULT] && !flags_q[CIE_BIT_BUS_FAULT]
		|=> !flags_q[CIE_BIT_BUS_FAULT])
		else $error("bus fault flag set while disabled");
	arb_flag_set_a: assert property (
		events_i.arb_loss && capture_armed_q && enables_q[CIE_BIT_ARB_LOSS]
		|=> flags_q[CIE_BIT_ARB_LOSS])
		else $error("arbitration loss flag not set");
	arb_flag_gate_a: assert property (
		!enables_q[CIE_BIT_ARB_LOSS] && !flags_q[CIE_BIT_ARB_LOSS]
		|=> !flags_q[CIE_BIT_ARB_LOSS])
		else $error("arbitration loss flag set while disabled");
	arb_flag_block_a: assert property (
		!capture_armed_q && !flags_q[CIE_BIT_ARB_LOSS]
		|=> !flags_q[CIE_BIT_ARB_LOSS])
		else $error("arbitration loss flag set while unread");
	passive_set_a: assert property (
		events_i.passive_change && enables_q[CIE_BIT_PASSIVE]
		|=> flags_q[CIE_BIT_PASSIVE])
		else $error("passive change flag not set");
	passive_gate_a: assert property (
		!enables_q[CIE_BIT_PASSIVE] && !flags_q[CIE_BIT_PASSIVE]
		|=> !flags_q[CIE_BIT_PASSIVE])
		else $error("passive change flag set while disabled");
	wake_set_a: assert property (
		events_i.wake && enables_q[CIE_BIT_WAKE]
		|=> flags_q[CIE_BIT_WAKE])
		else $error("wake flag not set");
	wake_gate_a: assert property (
		!enables_q[CIE_BIT_WAKE] && !flags_q[CIE_BIT_WAKE]
		|=> !flags_q[CIE_BIT_WAKE])
		else $error("wake flag set while disabled");
	overrun_set_a: assert property (
		events_i.overrun_rise && enables_q[CIE_BIT_OVERRUN]
		|=> flags_q[CIE_BIT_OVERRUN])
		else $error("overrun flag not set");
	overrun_gate_a: assert property (
		!enables_q[CIE_BIT_OVERRUN] && !flags_q[CIE_BIT_OVERRUN]
		|=> !flags_q[CIE_BIT_OVERRUN])
		else $error("overrun flag set while disabled");
	warning_set_a: assert property (
		events_i.warning_change && enables_q[CIE_BIT_WARNING]
		|=> flags_q[CIE_BIT_WARNING])
		else $error("warning flag not set");
	warning_gate_a: assert property (
		!enables_q[CIE_BIT_WARNING] && !flags_q[CIE_BIT_WARNING]
		|=> !flags_q[CIE_BIT_WARNING])
		else $error("warning flag set while disabled");
	tx_done_set_a: assert property (
		events_i.tx_released && enables_q[CIE_BIT_TX_DONE]
		|=> flags_q[CIE_BIT_TX_DONE])
		else $error("transmit flag not set");
	tx_done_gate_a: assert property (
		!enables_q[CIE_BIT_TX_DONE] && !flags_q[CIE_BIT_TX_DONE]
		|=> !flags_q[CIE_BIT_TX_DONE])
		else $error("transmit flag set while disabled");
	flag_read_clr_a: assert property (
		rd_flags && !flag_set[CIE_BIT_WAKE]
		|=> !flags_q[CIE_BIT_WAKE])
		else $error("flag not cleared by read");
	arb_read_clr_a: assert property (
		rd_flags && !flag_set[CIE_BIT_ARB_LOSS]
		|=> !flags_q[CIE_BIT_ARB_LOSS])
		else $error("arbitration loss flag not cleared by read");
	all_read_clr_a: assert property (
		rd_flags && flag_set == '0
		|=> flags_q == '0)
		else $error("flags not all cleared by read");
	flags_read_a: assert property (
		rd_flags
		|=> wb_dat_o[7:0] == $past(flags_view))
		else $error("flag read data wrong");

	// ---------------------------------------------
	// checks: interrupt line
	// ---------------------------------------------
	rx_line_a: assert property (
		events_i.rx_full && enables_q[CIE_BIT_RX_PENDING]
		|=> !irq_n_o)
		else $error("line inactive with receive pending");
	rx_gate_line_a: assert property (
		!enables_q[CIE_BIT_RX_PENDING] && flags_q == '0
		|=> irq_n_o)
		else $error("line active with nothing pending");
	irq_line_a: assert property (
		|flags_q
		|=> !irq_n_o)
		else $error("line inactive while flag set");
	irq_idle_a: assert property (
		flags_view == 8'h00
		|=> irq_n_o)
		else $error("line active with no flag");

	// ---------------------------------------------
	// cover points
	// ---------------------------------------------
	cov_capture_c: cover property (events_i.arb_loss && capture_armed_q ##[1:50] rd_loss);
	cov_blocked_c: cover property (events_i.arb_loss && !capture_armed_q);
	cov_rx_irq_c: cover property (events_i.rx_full && enables_q[CIE_BIT_RX_PENDING] ##1 !irq_n_o);
	cov_set_clr_c: cover property (rd_flags && |flag_set);
	cov_overlap_c: cover property (events_i.arb_loss && capture_armed_q && rd_loss);
endmodule
`default_nettype wire

// file: cie_pkg.sv
// package: register map, field layout and types of the interrupt enable and capture block
package cie_pkg;
	// ---------------------------------------------
	// register map (printed offsets are indices)
	// ---------------------------------------------
	localparam int unsigned CIE_IDX_ENABLES = 4;
	localparam int unsigned CIE_IDX_LOSS_POS = 11;
	localparam int unsigned CIE_IDX_FLAGS = 3;
	localparam logic [5:0] CIE_ADR_ENABLES = 6'(CIE_IDX_ENABLES * 4);
	localparam logic [5:0] CIE_ADR_LOSS_POS = 6'(CIE_IDX_LOSS_POS * 4);
	localparam logic [5:0] CIE_ADR_FLAGS = 6'(CIE_IDX_FLAGS * 4);
	localparam logic [7:0] CIE_ENABLES_RST = 8'h00;
	localparam logic [7:0] CIE_FLAGS_RST = 8'h00;
	localparam logic [4:0] CIE_LOSS_POS_RST = 5'h00;
	localparam logic [2:0] CIE_LOSS_RSVD = 3'h0;
	// ---------------------------------------------
	// bit positions in enable and flag registers
	// ---------------------------------------------
	localparam int unsigned CIE_BIT_BUS_FAULT = 7;
	localparam int unsigned CIE_BIT_ARB_LOSS = 6;
	localparam int unsigned CIE_BIT_PASSIVE = 5;
	localparam int unsigned CIE_BIT_WAKE = 4;
	localparam int unsigned CIE_BIT_OVERRUN = 3;
	localparam int unsigned CIE_BIT_WARNING = 2;
	localparam int unsigned CIE_BIT_TX_DONE = 1;
	localparam int unsigned CIE_BIT_RX_PENDING = 0;
	localparam int unsigned CIE_NUM_SRC = 8;
	// loss position codes
	localparam logic [4:0] CIE_POS_ID_LAST_STD = 5'h0a;
	localparam logic [4:0] CIE_POS_SRTR = 5'h0b;
	localparam logic [4:0] CIE_POS_IDE = 5'h0c;
	localparam logic [4:0] CIE_POS_ID_FIRST_EXT = 5'h0d;
	localparam logic [4:0] CIE_POS_RTR_EXT = 5'h1f;

	// events from the protocol engine and status logic, one-cycle strobes except rx_full
	typedef struct packed {
		logic bus_fault;
		logic arb_loss;
		logic passive_change;
		logic wake;
		logic overrun_rise;
		logic warning_change;
		logic tx_released;
		logic rx_full;
	} cie_events_s;

	typedef enum logic [2:0] {
		CIE_BUS_IDLE = 3'b001,
		CIE_BUS_ACK = 3'b010,
		CIE_BUS_GAP = 3'b100
	} cie_bus_e;
endpackage

// file: cie_engine_model.sv
// model of the protocol engine that feeds event strobes and bit position
`timescale 1ns/1ps
`default_nettype none
module cie_engine_model
	import cie_pkg::*;
(
	// clock
	input wire logic clk_i,
	// event side
	output cie_events_s events_o,
	output logic [4:0] frame_bit_pos_o
);
	initial begin
		events_o = '0;
		frame_bit_pos_o = 5'h15;
	end
	// ---------------------------------------------
	// strobes last one cycle; position is only good with them
	// ---------------------------------------------
	task strobe(input logic [7:0] ev, input logic [4:0] pos);
		@(posedge clk_i);
		events_o <= cie_events_s'({ev[7:1], events_o.rx_full});
		frame_bit_pos_o <= pos;
		@(posedge clk_i);
		events_o <= cie_events_s'({7'h00, events_o.rx_full});
		// inverse so a stale position cannot pass for a capture
		frame_bit_pos_o <= ~pos;
	endtask
	// receive buffer full is a level
	task set_rx(input logic v);
		@(posedge clk_i);
		events_o.rx_full <= v;
	endtask
endmodule
`default_nettype wire

// file: can_irq_enable_arb_capture_tb.sv
// testbench for the interrupt enable and loss position block
`timescale 1ns/1ps
`default_nettype none
module can_irq_enable_arb_capture_tb;
	import cie_pkg::*;
	logic clk_i, rst_i, cyc, stb, we, wb_ack_o, irq_n_o;
	logic [5:0] adr;
	logic [3:0] sel, lane;
	logic [31:0] wdat, wb_dat_o, rd;
	cie_events_s ev;
	logic [4:0] pos;
	int num_errors, n_tests;
	logic [4:0] pt [7] = '{5'h00, 5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h1e, 5'h1f};
	cie_irq_enable_capture u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.events_i(ev), .frame_bit_pos_i(pos), .irq_n_o(irq_n_o));
	cie_engine_model u_eng (.clk_i(clk_i), .events_o(ev), .frame_bit_pos_o(pos));
	// ---------------------------------------------
	// helpers
	// ---------------------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task bus(input logic w, input logic [5:0] a, input logic [7:0] d);
		int n;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		sel <= lane;
		adr <= a;
		wdat <= {24'h000000, d};
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		chk(wb_ack_o, 1);
		rd = wb_dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	// line is registered, so allow the settle cycle
	task irq(input logic e);
		repeat (2) @(posedge clk_i);
		#1;
		chk(irq_n_o, e);
	endtask
	// ---------------------------------------------
	// scenarios
	// ---------------------------------------------
	task t_reset;
		bus(0, CIE_ADR_ENABLES, 0);
		chk(rd, 0);
		bus(0, CIE_ADR_FLAGS, 0);
		chk(rd, 0);
		bus(0, CIE_ADR_LOSS_POS, 0);
		chk(rd, 0);
		chk(irq_n_o, 1);
	endtask
	task t_access;
		bus(1, CIE_ADR_ENABLES, 8'ha5);
		bus(0, CIE_ADR_ENABLES, 0);
		chk(rd, 32'ha5);
		lane = 4'h2;
		bus(1, CIE_ADR_ENABLES, 8'h5a);
		lane = 4'h1;
		bus(0, CIE_ADR_ENABLES, 0);
		chk(rd, 32'ha5);
		bus(1, CIE_ADR_LOSS_POS, 8'hff);
		bus(0, CIE_ADR_LOSS_POS, 0);
		chk(rd, 0);
		bus(0, 6'h3c, 0);
		chk(rd, 0);
	endtask
	task t_sources;
		for (int i = 1; i < 8; i++) begin
			bus(1, CIE_ADR_ENABLES, 8'h01 << i);
			u_eng.strobe(8'h01 << i, 5'h03);
			irq(0);
			bus(0, CIE_ADR_FLAGS, 0);
			chk(rd, 32'h1 << i);
			irq(1);
			if (i == 6) bus(0, CIE_ADR_LOSS_POS, 0);
			bus(1, CIE_ADR_ENABLES, ~(8'h01 << i));
			u_eng.strobe(8'h01 << i, 5'h03);
			irq(1);
			bus(0, CIE_ADR_FLAGS, 0);
			chk(rd, 0);
			if (i == 6) bus(0, CIE_ADR_LOSS_POS, 0);
		end
	endtask
	task t_rx;
		bus(1, CIE_ADR_ENABLES, 8'h01);
		u_eng.set_rx(1);
		irq(0);
		bus(0, CIE_ADR_FLAGS, 0);
		chk(rd, 1);
		bus(0, CIE_ADR_FLAGS, 0);
		chk(rd, 1);
		bus(1, CIE_ADR_ENABLES, 8'h00);
		irq(1);
		u_eng.set_rx(0);
	endtask
	task t_capture;
		bus(1, CIE_ADR_ENABLES, 8'h40);
		for (int k = 0; k < 7; k++) begin
			u_eng.strobe(8'h40, pt[k]);
			bus(0, CIE_ADR_FLAGS, 0);
			chk(rd, 32'h40);
			u_eng.strobe(8'h40, ~pt[k]);
			bus(0, CIE_ADR_FLAGS, 0);
			chk(rd, 0);
			bus(0, CIE_ADR_LOSS_POS, 0);
			chk(rd, {27'h0, pt[k]});
		end
	endtask
	// loss and position read in one cycle: armed takes the loss, disarmed drops it
	task t_overlap;
		fork
			bus(0, CIE_ADR_LOSS_POS, 0);
			u_eng.strobe(8'h40, 5'h07);
		join
		chk(rd, 32'h1f);
		u_eng.strobe(8'h40, 5'h08);
		bus(0, CIE_ADR_LOSS_POS, 0);
		chk(rd, 32'h07);
		bus(0, CIE_ADR_FLAGS, 0);
		chk(rd, 32'h40);
		u_eng.strobe(8'h40, 5'h09);
		bus(0, CIE_ADR_FLAGS, 0);
		chk(rd, 32'h40);
		fork
			bus(0, CIE_ADR_LOSS_POS, 0);
			u_eng.strobe(8'h40, 5'h0a);
		join
		chk(rd, 32'h09);
		bus(0, CIE_ADR_FLAGS, 0);
		chk(rd, 32'h00);
		bus(0, CIE_ADR_LOSS_POS, 0);
		chk(rd, 32'h09);
	endtask
	task results;
		$display("tests %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// ---------------------------------------------
	// clock, reset, sequence, watchdog
	// ---------------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	initial begin
		rst_i = 1'b1;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		sel = 4'h0;
		lane = 4'h1;
		adr = 6'h00;
		wdat = 32'h0;
		num_errors = 0;
		n_tests = 0;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_access();
		t_sources();
		t_rx();
		t_capture();
		t_overlap();
		results();
	end
	// whole-run time limit; bus already gives up on a hung handshake after 50 cycles
	initial begin
		#50000;
		num_errors++;
		results();
	end
endmodule
`default_nettype wire
